// file: bench/commissioning_test_props.sv
`timescale 1ns/1ps
module commissioning_test_props (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  // register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  // relay internals
  input wire logic [commissioning_test_pkg::OUT_COUNT-1:0] output_cmd_in,
  input wire logic opto_injection_in,
  input wire logic opto_lockout_in,
  // observed outputs
  input wire logic [commissioning_test_pkg::OUT_COUNT-1:0] contact_drive_out,
  input wire logic [commissioning_test_pkg::LAMP_COUNT-1:0] red_lamp_out,
  input wire logic [commissioning_test_pkg::LAMP_COUNT-1:0] green_lamp_out,
  input wire logic alarm_lamp_out,
  input wire commissioning_test_pkg::test_flags_t flags_out
);
  import commissioning_test_pkg::*;
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!reset_n_in);
  logic inj;
  logic lock;
  assign inj = flags_out.alarm_injection;
  assign lock = flags_out.alarm_lockout;

  property p_alarm_yellow;
    alarm_lamp_out == (inj || lock);
  endproperty
  a_alarm_yellow: assert property (p_alarm_yellow)
    else $error("yellow alarm disagrees with test state");
  property p_inj_flags;
    (flags_out.breaker_data_freeze == inj) && (flags_out.cause_is_test == inj);
  endproperty
  a_inj_flags: assert property (p_inj_flags)
    else $error("breaker freeze or cause flag wrong");
  property p_quality;
    (flags_out.quality_test == (inj || lock)) && (flags_out.mode_test_blocked == lock);
  endproperty
  a_quality: assert property (p_quality)
    else $error("quality or mode flag wrong");
  property p_lock_wins;
    lock |-> !inj;
  endproperty
  a_lock_wins: assert property (p_lock_wins)
    else $error("both test states shown at once");
  property p_opto_inj;
    opto_injection_in [*2] |-> (inj || lock);
  endproperty
  a_opto_inj: assert property (p_opto_inj)
    else $error("mapped opto did not enter injection test");
  property p_opto_lock;
    opto_lockout_in [*2] |-> lock;
  endproperty
  a_opto_lock: assert property (p_opto_lock)
    else $error("mapped opto did not enter lockout");
  // guard on past reset: outputs are held at zero on the first edge after release
  property p_drive_service;
    $past(reset_n_in) && !lock && !$past(lock) && !$past(lock, 2)
      |-> contact_drive_out == $past(output_cmd_in);
  endproperty
  a_drive_service: assert property (p_drive_service)
    else $error("contacts do not follow protection commands");
  property p_lock_hold;
    lock && $past(lock) && !$past(reg_wr_in) && !$past(reg_wr_in, 2)
      |-> $stable(contact_drive_out);
  endproperty
  a_lock_hold: assert property (p_lock_hold)
    else $error("contacts moved in lockout without a command");
  property p_lamp_trial;
    reg_wr_in && reg_addr_in == OFS_LAMP_CMD && reg_wdata_in[0]
      |-> ##2 (&red_lamp_out && &green_lamp_out);
  endproperty
  a_lamp_trial: assert property (p_lamp_trial)
    else $error("lamp trial did not light all lamps");
endmodule

bind commissioning_test_control commissioning_test_props u_commissioning_test_props (
  .clk_sys_in, .reset_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .output_cmd_in,
  .opto_injection_in, .opto_lockout_in, .contact_drive_out, .red_lamp_out, .green_lamp_out,
  .alarm_lamp_out, .flags_out
);

// file: bench/monitor_test_box.sv
`timescale 1ns/1ps
module monitor_test_box (
  // monitor port pins
  input wire logic [commissioning_test_pkg::PROBE_COUNT-1:0] probe_pin_in,
  input wire logic buzzer_en_in,
  // box indication
  output logic [commissioning_test_pkg::PROBE_COUNT-1:0] box_lamp_out,
  output logic buzz_out
);
  import commissioning_test_pkg::*;
  // no latching, so a short pulse shows only as long as it lasts
  assign box_lamp_out = probe_pin_in;
  assign buzz_out = buzzer_en_in && (|probe_pin_in);
endmodule

// file: bench/testbench.sv
`timescale 1ns/1ps
module testbench;
  import commissioning_test_pkg::*;
  logic clk_sys_in, reset_n_in, clk_en_in, reg_wr_in, reg_rd_in, alarm_lamp_out, buzz;
  logic opto_injection_in, opto_lockout_in;
  logic [7:0] reg_addr_in;
  logic [31:0] reg_wdata_in, reg_rdata_out, opto_in, output_cmd_in, contact_drive_out;
  logic [SIG_COUNT-1:0] signal_bus_in;
  logic [LAMP_COUNT-1:0] red_lamp_in, green_lamp_in, red_lamp_out, green_lamp_out;
  logic [PROBE_COUNT-1:0] monitor_pin_out, box_lamp;
  test_flags_t flags_out;
  int err_count, n_compared, cycles;
  localparam logic [8:0] SEL_IDX [8] = '{9'h000, 9'h1FF, 9'h12C, 9'h001, 9'h002, 9'h0FF,
                                         9'h100, 9'h03F};
  localparam logic [7:0] PAT = 8'hA6;

  commissioning_test_control u_commissioning_test_control (
    .clk_sys_in, .reset_n_in, .clk_en_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
    .reg_rdata_out, .opto_in, .signal_bus_in, .output_cmd_in, .red_lamp_in, .green_lamp_in,
    .opto_injection_in, .opto_lockout_in, .contact_drive_out, .red_lamp_out, .green_lamp_out,
    .alarm_lamp_out, .flags_out, .monitor_pin_out
  );
  monitor_test_box u_monitor_test_box (.probe_pin_in(monitor_pin_out), .buzzer_en_in(1'b1),
    .box_lamp_out(box_lamp), .buzz_out(buzz));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  initial begin
    clk_sys_in = 1'b0;
    forever #4 clk_sys_in = ~clk_sys_in;
  end
  task automatic test_done;
    $display("compared %0d errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 4000) begin
      err_count++;
      test_done();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe edge
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
    #1;
    chk(what, exp, reg_rdata_out);
  endtask
  task automatic settle;
    repeat (3) @(posedge clk_sys_in);
    #1;
  endtask
  task automatic flags_chk(input string what, input logic [7:0] exp);
    settle();
    chk(what, {24'h0, exp}, {24'h0, flags_out});
  endtask

  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial begin
    reset_n_in = 1'b0;
    clk_en_in = 1'b1;
    {reg_wr_in, reg_rd_in, opto_injection_in, opto_lockout_in} = 4'h0;
    reg_addr_in = 8'h00;
    reg_wdata_in = 32'h0;
    opto_in = 32'hA5C30F01;
    output_cmd_in = 32'h12345678;
    signal_bus_in = '0;
    red_lamp_in = 18'h2A5C3;
    green_lamp_in = 18'h1F00F;
    repeat (4) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    rd(OFS_OPTO_VIEW, 32'hA5C30F01, "opto view");
    rd(OFS_DRIVE_VIEW, 32'h12345678, "drive view");
    rd(OFS_RED_VIEW, 32'h0002A5C3, "red view");
    rd(OFS_GREEN_VIEW, 32'h0001F00F, "green view");
    rd(OFS_LAMP_VIEW, 32'h000000C3, "small lamp view");
    chk("yellow lamps", {14'h0, 18'h2A5C3 & 18'h1F00F}, {14'h0, red_lamp_out & green_lamp_out});
    rd(8'h4C, 32'h0, "unmapped read");
    rd(OFS_TRIAL_MASK, 32'h0, "trial mask reset");
    for (int i = 0; i < PROBE_COUNT; i++) begin
      rd(OFS_PROBE_SEL0 + 8'(4 * i), 32'(64 + i), "selector reset");
      signal_bus_in[SEL_IDX[i]] <= PAT[i];
      wr(OFS_PROBE_SEL0 + 8'(4 * i), {23'h0, SEL_IDX[i]});
    end
    settle();
    rd(OFS_PROBE_VIEW, {24'h0, PAT}, "probe view");
    chk("monitor pins", {24'h0, PAT}, {24'h0, monitor_pin_out});
    chk("box lamps", {24'h0, PAT}, {24'h0, box_lamp});
    chk("box buzzer", 32'h1, {31'h0, buzz});
    rd(OFS_PROBE_SEL0 + 8'h04, 32'h000001FF, "top selector");
    wr(OFS_TRIAL_MASK, 32'hFFFFFFFF);
    wr(OFS_CONTACT_CMD, 32'h1);
    settle();
    rd(OFS_TRIAL_MASK, 32'h0, "mask refused");
    chk("no trial outside lockout", 32'h12345678, contact_drive_out);
    wr(OFS_TEST_STATE, 32'h1);
    flags_chk("injection flags", 8'hBE);
    chk("alarm lamp injection", 32'h1, {31'h0, alarm_lamp_out});
    wr(OFS_TEST_STATE, 32'h3);
    settle();
    rd(OFS_TEST_STATE, 32'h1, "state code 3 refused");
    wr(OFS_TEST_STATE, 32'h2);
    flags_chk("lockout flags", 8'h65);
    chk("alarm lamp lockout", 32'h1, {31'h0, alarm_lamp_out});
    output_cmd_in <= 32'hCAFE0001;
    rd(OFS_DRIVE_VIEW, 32'hCAFE0001, "drive view in lockout");
    chk("contacts blocked", 32'h0, contact_drive_out);
    wr(OFS_TRIAL_MASK, 32'h80000001);
    wr(OFS_CONTACT_CMD, 32'h1);
    settle();
    chk("trial assert", 32'h80000001, contact_drive_out);
    rd(OFS_CONTACT_CMD, 32'h0, "command idle after assert");
    wr(OFS_TRIAL_MASK, 32'h00000100);
    settle();
    chk("trial held", 32'h80000001, contact_drive_out);
    wr(OFS_CONTACT_CMD, 32'h2);
    settle();
    chk("trial release", 32'h0, contact_drive_out);
    rd(OFS_CONTACT_CMD, 32'h0, "command idle after release");
    wr(OFS_TEST_STATE, 32'h0);
    flags_chk("service flags", 8'h00);
    chk("service contacts", 32'hCAFE0001, contact_drive_out);
    opto_lockout_in <= 1'b1;
    flags_chk("opto lockout", 8'h65);
    opto_lockout_in <= 1'b0;
    opto_injection_in <= 1'b1;
    flags_chk("opto injection", 8'hBE);
    opto_injection_in <= 1'b0;
    flags_chk("opto released", 8'h00);
    red_lamp_in <= '0;
    green_lamp_in <= '0;
    wr(OFS_LAMP_CMD, 32'h1);
    settle();
    chk("lamp trial", 32'h3FFFF, {14'h0, red_lamp_out & green_lamp_out});
    rd(OFS_LAMP_CMD, 32'h1, "lamp trial running");
    // the full trial is two seconds; a second reset cuts it short
    @(posedge clk_sys_in);
    reset_n_in <= 1'b0;
    repeat (4) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    settle();
    chk("lamps after reset", 32'h0, {14'h0, red_lamp_out | green_lamp_out});
    test_done();
  end
endmodule

// file: rtl/commissioning_test_control.sv
`timescale 1ns/1ps
// Function
// - opto view: 1 energized, 0 de-energized
// - drive view shows commanded output relay signals
// - drive view shows service commands in test
// - probe view holds eight selected bus signals
// - eight selectors, index range 0 to 511
// - each probe also drives own monitor pin
// - injection test raises alarm, yellow lamp, message
// - injection test freezes breaker data, cause test
// - both states set quality test; device mode
// - mapped opto also enters injection test
// - lockout raises alarm, yellow lamp, message
// - lockout blocks contacts; trial mask, command available
// - mapped opto also enters lockout
// - trial mask: one bit per contact
// - assert operates masked contacts, command reads idle
// - release frees contacts, command reads idle
// - lamp trial lights all lamps about 2 s
// - small variant: eight bit lamp view
// - large variants: 18-bit red and green views
// - red and green both set means yellow
module commissioning_test_control (
  // clock, reset, enable
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic clk_en_in,
  // register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  // relay internals
  input wire logic [commissioning_test_pkg::OPTO_COUNT-1:0] opto_in,
  input wire logic [commissioning_test_pkg::SIG_COUNT-1:0] signal_bus_in,
  input wire logic [commissioning_test_pkg::OUT_COUNT-1:0] output_cmd_in,
  input wire logic [commissioning_test_pkg::LAMP_COUNT-1:0] red_lamp_in,
  input wire logic [commissioning_test_pkg::LAMP_COUNT-1:0] green_lamp_in,
  input wire logic opto_injection_in,
  input wire logic opto_lockout_in,
  // outputs towards the plant and protocols
  output logic [commissioning_test_pkg::OUT_COUNT-1:0] contact_drive_out,
  output logic [commissioning_test_pkg::LAMP_COUNT-1:0] red_lamp_out,
  output logic [commissioning_test_pkg::LAMP_COUNT-1:0] green_lamp_out,
  output logic alarm_lamp_out,
  output commissioning_test_pkg::test_flags_t flags_out,
  // monitor port
  output logic [commissioning_test_pkg::PROBE_COUNT-1:0] monitor_pin_out
);
  import commissioning_test_pkg::*;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [SIG_IDX_W-1:0] probe_sel_reg [PROBE_COUNT];
  test_state_t test_setting_reg;
  test_state_t test_state;
  logic [OUT_COUNT-1:0] trial_mask_reg;
  logic [OUT_COUNT-1:0] trial_hold_reg;
  logic trial_active_reg;
  lamp_state_t lamp_state_reg;
  logic [LAMP_CNT_W-1:0] lamp_cnt_reg;
  logic [OPTO_COUNT-1:0] opto_view_reg;
  logic [OUT_COUNT-1:0] drive_view_reg;
  logic [PROBE_COUNT-1:0] probe_view_reg;
  logic [LAMP_COUNT-1:0] red_view_reg;
  logic [LAMP_COUNT-1:0] green_view_reg;
  logic [PROBE_COUNT-1:0] probe_now;
  logic [OUT_COUNT-1:0] drive_next;
  logic [LAMP_COUNT-1:0] red_next;
  logic [LAMP_COUNT-1:0] green_next;
  logic in_lockout;
  logic in_injection;
  logic wr_contact;
  contact_cmd_t contact_cmd;
  logic wr_lamp;

  // ------------------------------------------------------------
  // decoding
  // ------------------------------------------------------------
  // selector index for a probe address, or PROBE_COUNT when not one
  function automatic int probe_slot(input logic [7:0] addr);
    int slot;
    slot = PROBE_COUNT;
    for (int i = 0; i < PROBE_COUNT; i++) begin
      if (addr == 8'(OFS_PROBE_SEL0 + 8'(i) * PROBE_SEL_STRIDE)) begin
        slot = i;
      end
    end
    return slot;
  endfunction

  // ------------------------------------------------------------
  // test state: setting or mapped opto, lockout wins if both
  // ------------------------------------------------------------
  always_comb begin
    if (opto_lockout_in || test_setting_reg == TEST_LOCKOUT) begin
      test_state = TEST_LOCKOUT;
    end else if (opto_injection_in || test_setting_reg == TEST_INJECTION) begin
      test_state = TEST_INJECTION;
    end else begin
      test_state = TEST_DISABLED;
    end
  end
  assign in_lockout = (test_state == TEST_LOCKOUT);
  assign in_injection = (test_state == TEST_INJECTION);

  assign wr_contact = reg_wr_in && reg_addr_in == OFS_CONTACT_CMD;
  assign contact_cmd = contact_cmd_t'(reg_wdata_in[1:0]);
  assign wr_lamp = reg_wr_in && reg_addr_in == OFS_LAMP_CMD && reg_wdata_in[0];

  // ------------------------------------------------------------
  // settings
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      test_setting_reg <= TEST_DISABLED;
      trial_mask_reg <= TRIAL_MASK_RESET;
    end else if (clk_en_in && reg_wr_in) begin
      // going back to disabled restores service
      if (reg_addr_in == OFS_TEST_STATE && reg_wdata_in[1:0] != 2'b11) begin
        test_setting_reg <= test_state_t'(reg_wdata_in[1:0]);
      end
      if (reg_addr_in == OFS_TRIAL_MASK && in_lockout) begin
        trial_mask_reg <= reg_wdata_in[OUT_COUNT-1:0];
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < PROBE_COUNT; g++) begin : gen_probe
      always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
          probe_sel_reg[g] <= SIG_IDX_W'(PROBE_SEL_RESET0 + SIG_IDX_W'(g));
        end else if (clk_en_in && reg_wr_in && probe_slot(reg_addr_in) == g) begin
          probe_sel_reg[g] <= reg_wdata_in[SIG_IDX_W-1:0];
        end
      end
      assign probe_now[g] = signal_bus_in[probe_sel_reg[g]];
    end
  endgenerate

  // ------------------------------------------------------------
  // contact trial: hold stays until released or lockout ends
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      trial_hold_reg <= '0;
      trial_active_reg <= 1'b0;
    end else if (clk_en_in) begin
      if (!in_lockout) begin
        trial_hold_reg <= '0;
        trial_active_reg <= 1'b0;
      end else if (wr_contact && contact_cmd == CMD_ASSERT) begin
        trial_hold_reg <= trial_mask_reg;
        trial_active_reg <= 1'b1;
      end else if (wr_contact && contact_cmd == CMD_RELEASE) begin
        trial_hold_reg <= '0;
        trial_active_reg <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // lamp trial
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      lamp_state_reg <= LAMP_IDLE;
      lamp_cnt_reg <= '0;
    end else if (clk_en_in) begin
      case (lamp_state_reg)
        LAMP_IDLE: begin
          if (wr_lamp) begin
            lamp_state_reg <= LAMP_RUN;
            lamp_cnt_reg <= LAMP_CNT_W'(LAMP_TRIAL_CYCLES - 1);
          end
        end
        LAMP_RUN: begin
          if (lamp_cnt_reg == '0) begin
            lamp_state_reg <= LAMP_IDLE;
          end else begin
            lamp_cnt_reg <= lamp_cnt_reg - 1'b1;
          end
        end
        default: begin
          lamp_state_reg <= LAMP_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // views and outputs
  // ------------------------------------------------------------
  // protection commands never reach contacts in lockout
  assign drive_next = in_lockout ? trial_hold_reg : output_cmd_in;
  assign red_next = (lamp_state_reg == LAMP_RUN) ? '1 : red_lamp_in;
  assign green_next = (lamp_state_reg == LAMP_RUN) ? '1 : green_lamp_in;

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      opto_view_reg <= '0;
      drive_view_reg <= '0;
      probe_view_reg <= '0;
      red_view_reg <= '0;
      green_view_reg <= '0;
      contact_drive_out <= '0;
      red_lamp_out <= '0;
      green_lamp_out <= '0;
      monitor_pin_out <= '0;
    end else if (clk_en_in) begin
      opto_view_reg <= opto_in;
      // view is the service command, not the contact state
      drive_view_reg <= output_cmd_in;
      probe_view_reg <= probe_now;
      monitor_pin_out <= probe_now;
      red_view_reg <= red_next;
      green_view_reg <= green_next;
      contact_drive_out <= drive_next;
      red_lamp_out <= red_next;
      green_lamp_out <= green_next;
    end
  end

  // ------------------------------------------------------------
  // alarms and protocol flags
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      flags_out <= '0;
      alarm_lamp_out <= 1'b0;
    end else if (clk_en_in) begin
      flags_out.alarm_injection <= in_injection;
      flags_out.alarm_lockout <= in_lockout;
      flags_out.alarm_lamp <= in_injection || in_lockout;
      flags_out.breaker_data_freeze <= in_injection;
      flags_out.cause_is_test <= in_injection;
      flags_out.quality_test <= in_injection || in_lockout;
      flags_out.mode_test <= in_injection;
      flags_out.mode_test_blocked <= in_lockout;
      alarm_lamp_out <= in_injection || in_lockout;
    end
  end

  // ------------------------------------------------------------
  // read port: data one cycle after the strobe
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      reg_rdata_out <= '0;
    end else if (clk_en_in) begin
      reg_rdata_out <= '0;
      if (reg_rd_in) begin
        case (reg_addr_in)
          OFS_OPTO_VIEW: reg_rdata_out <= opto_view_reg;
          OFS_DRIVE_VIEW: reg_rdata_out <= drive_view_reg;
          OFS_PROBE_VIEW: reg_rdata_out <= 32'(probe_view_reg);
          OFS_LAMP_VIEW: reg_rdata_out <= 32'(red_view_reg[SMALL_LAMP_COUNT-1:0]);
          OFS_TEST_STATE: reg_rdata_out <= 32'(test_state);
          OFS_TRIAL_MASK: reg_rdata_out <= trial_mask_reg;
          // contact commands always read back idle once taken
          OFS_CONTACT_CMD: reg_rdata_out <= 32'(CMD_IDLE);
          OFS_LAMP_CMD: reg_rdata_out <= 32'(lamp_state_reg);
          OFS_RED_VIEW: reg_rdata_out <= 32'(red_view_reg);
          OFS_GREEN_VIEW: reg_rdata_out <= 32'(green_view_reg);
          OFS_STATUS: reg_rdata_out <= {29'h0, trial_active_reg, in_lockout, in_injection};
          default: begin
            if (probe_slot(reg_addr_in) < PROBE_COUNT) begin
              reg_rdata_out <= 32'(probe_sel_reg[probe_slot(reg_addr_in)]);
            end
          end
        endcase
      end
    end
  end

endmodule

// file: rtl/commissioning_test_pkg.sv
package commissioning_test_pkg;

  // ------------------------------------------------------------
  // sizes
  // ------------------------------------------------------------
  localparam int OPTO_COUNT = 32;
  localparam int OUT_COUNT = 32;
  localparam int PROBE_COUNT = 8;
  localparam int SIG_COUNT = 512;
  localparam int SIG_IDX_W = 9;
  localparam int LAMP_COUNT = 18;
  localparam int SMALL_LAMP_COUNT = 8;

  // ------------------------------------------------------------
  // register offsets (byte addresses, one word each)
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_OPTO_VIEW = 8'h00;
  localparam logic [7:0] OFS_DRIVE_VIEW = 8'h04;
  localparam logic [7:0] OFS_PROBE_VIEW = 8'h08;
  localparam logic [7:0] OFS_LAMP_VIEW = 8'h0C;
  localparam logic [7:0] OFS_PROBE_SEL0 = 8'h10;
  localparam logic [7:0] OFS_TEST_STATE = 8'h30;
  localparam logic [7:0] OFS_TRIAL_MASK = 8'h34;
  localparam logic [7:0] OFS_CONTACT_CMD = 8'h38;
  localparam logic [7:0] OFS_LAMP_CMD = 8'h3C;
  localparam logic [7:0] OFS_RED_VIEW = 8'h40;
  localparam logic [7:0] OFS_GREEN_VIEW = 8'h44;
  localparam logic [7:0] OFS_STATUS = 8'h48;
  localparam logic [7:0] PROBE_SEL_STRIDE = 8'h04;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [SIG_IDX_W-1:0] PROBE_SEL_RESET0 = 9'h040;
  localparam logic [OUT_COUNT-1:0] TRIAL_MASK_RESET = 32'h00000000;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam longint CLK_HZ = 125000000;
  localparam longint LAMP_TRIAL_MS = 2000;
  localparam longint LAMP_TRIAL_CYCLES = (CLK_HZ / 1000) * LAMP_TRIAL_MS;
  localparam int LAMP_CNT_W = 28;

  // ------------------------------------------------------------
  // encodings
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    TEST_DISABLED = 2'b00,
    TEST_INJECTION = 2'b01,
    TEST_LOCKOUT = 2'b10
  } test_state_t;

  typedef enum logic [1:0] {
    CMD_IDLE = 2'b00,
    CMD_ASSERT = 2'b01,
    CMD_RELEASE = 2'b10
  } contact_cmd_t;

  typedef enum logic [1:0] {
    LAMP_IDLE = 2'b00,
    LAMP_RUN = 2'b01
  } lamp_state_t;

  // quality and alarm flags towards the protocol stacks
  typedef struct packed {
    logic alarm_injection;
    logic alarm_lockout;
    logic alarm_lamp;
    logic breaker_data_freeze;
    logic cause_is_test;
    logic quality_test;
    logic mode_test;
    logic mode_test_blocked;
  } test_flags_t;

  // register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

endpackage
